// ==== eec_pkg.sv ====
/*
 * eec_pkg: constants and types of the serial EEPROM command engine.
 * Assumes one serial frame per chip-select low period, mode 0/3 framing.
 */
package eec_pkg;

    // opcodes, first byte of every frame
    localparam logic [7:0] OP_WEL_SET   = 8'h06;
    localparam logic [7:0] OP_WEL_CLR   = 8'h04;
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_WRITE     = 8'h02;
    localparam logic [7:0] OP_SR_READ   = 8'h05;
    localparam logic [7:0] OP_SR_WRITE  = 8'h01;

    // array and page geometry
    localparam int          ADDR_W      = 16;
    localparam int          MEM_AW      = 15;
    localparam int          MEM_WORDS   = 32768;
    localparam int          PAGE_AW     = 6;
    localparam int          PAGE_BYTES  = 64;

    // frame position, in whole bytes received and bit within byte
    localparam logic [2:0]  BIT_LAST        = 3'h7;
    localparam logic [2:0]  BYTE_OPCODE     = 3'h0;
    localparam logic [2:0]  BYTE_SR_DATA    = 3'h1;
    localparam logic [2:0]  BYTE_ADDR_DONE  = 3'h2;
    localparam logic [2:0]  BYTE_DATA_FIRST = 3'h3;
    localparam logic [2:0]  BYTE_SAT        = 3'h7;

    // block-protect codes and the lower bound of the quarter and half protected blocks
    localparam logic [1:0]  BP_NONE         = 2'h0;
    localparam logic [1:0]  BP_QUARTER      = 2'h1;
    localparam logic [1:0]  BP_HALF         = 2'h2;
    localparam logic [1:0]  BP_ALL          = 2'h3;
    localparam logic [14:0] BOUND_QUARTER   = 15'h6000;
    localparam logic [14:0] BOUND_HALF      = 15'h4000;

    // reset values of the status bits
    localparam logic        PROTECT_PIN_ENABLE_RST        = 1'b0;
    localparam logic [1:0]  BP_RST          = 2'h0;
    localparam logic        WEL_RST         = 1'b0;

    // self-timed program cycle, longest time, rounded down
    localparam int          PROG_TIME_NS    = 5000000;
    localparam int          CLK_PERIOD_NS   = 4;
    localparam int          PROG_CYCLES     = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int          TIMER_W         = 21;

    // decoded command of the current frame
    typedef enum logic [2:0] {
        CMD_NONE     = 3'b000,
        CMD_WEL_SET  = 3'b001,
        CMD_WEL_CLR  = 3'b010,
        CMD_READ     = 3'b011,
        CMD_WRITE    = 3'b100,
        CMD_SR_READ  = 3'b101,
        CMD_SR_WRITE = 3'b110
    } eec_cmd_t;

    // core sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01,
        ST_WAIT = 2'b10
    } eec_state_t;

    // status byte layout
    typedef struct packed {
        logic       protect_pin_enable;
        logic [2:0] zero;
        logic       bp_hi;
        logic       bp_lo;
        logic       wel;
        logic       busy;
    } eec_status_t;

    // levels passed from the serial side to the core side
    typedef struct packed {
        logic wel_set;
        logic wel_clr;
        logic wr_armed;
        logic sr_armed;
    } eec_req_t;

endpackage

// ==== eec_spi_eeprom_engine.sv ====
/*
 * eec_spi_eeprom_engine: serial-bus command engine of a 32K x 8 EEPROM,
 * with the array, page buffer, status register and program timer.
 * Assumes chip_select_n_in is high at power-up, and that serial clock,
 * select, pause and serial input are driven by one bus controller.
 */
`timescale 1ns/10ps

module eec_spi_eeprom_engine
    import eec_pkg::*;
#(
    parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
)
(
    // core clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    // serial link
    input  wire logic        sck_in,
    input  wire logic        chip_select_n_in,
    input  wire logic        serial_in_in,
    input  wire logic        pause_n_in,
    input  wire logic        protect_n_in,
    output logic             serial_data_out,
    output logic             serial_oe_n_out,
    // status view
    output logic [7:0]       status_out,
    output logic             busy_out
);

    // array and page buffer
    logic [7:0]       mem       [MEM_WORDS];
    logic [7:0]       page_buf  [PAGE_BYTES];

    // serial side state, cleared by select high
    logic [2:0]       byte_cnt_reg, byte_cnt_next;
    logic [2:0]       bpos_reg, bpos_next;
    eec_cmd_t         cmd_reg, cmd_next;
    eec_req_t         req_reg, req_next;
    // serial side data, kept across select high
    logic [15:0]      shift_reg, shift_next;
    logic [15:0]      addr_reg, addr_next;
    logic [5:0]       pg_idx_reg, pg_idx_next;
    logic [63:0]      pg_mask_reg, pg_mask_next;
    logic [7:0]       sr_data_reg, sr_data_next;
    logic             pb_we;
    logic [7:0]       byte_in;
    // output side, updated at falling edges
    logic             so_bit_reg, so_bit_next;
    logic             so_en_reg, so_en_next;
    logic [7:0]       rd_byte;

    // core side
    logic [5:0]       sync1_reg, sync2_reg, sync3_reg, sync4_reg;
    eec_req_t         req_s, req_d, req_old;
    logic             cs_s, cs_d, prot_n_s;
    eec_state_t       state_reg, state_next;
    logic [TIMER_W-1:0] timer_reg, timer_next;
    logic [5:0]       prog_idx_reg, prog_idx_next;
    logic             wel_reg, wel_next;
    logic             protect_pin_enable_reg, protect_pin_enable_next;
    logic [1:0]       bp_reg, bp_next;
    logic             prot_low_reg, prot_low_next;
    logic             mem_we;
    logic [14:0]      mem_waddr;
    eec_status_t      status;

    // decode of a completed opcode; busy refuses all but status read
    function automatic eec_cmd_t decode_op(input logic [7:0] op, input logic busy);
        eec_cmd_t c;
        c = CMD_NONE;
        unique case (op)
            OP_WEL_SET:  c = CMD_WEL_SET;
            OP_WEL_CLR:  c = CMD_WEL_CLR;
            OP_READ:     c = CMD_READ;
            OP_WRITE:    c = CMD_WRITE;
            OP_SR_READ:  c = CMD_SR_READ;
            OP_SR_WRITE: c = CMD_SR_WRITE;
            default:     c = CMD_NONE;
        endcase
        if (busy && c != CMD_SR_READ)
            c = CMD_NONE;
        return c;
    endfunction

    // block-protect test of an array address
    function automatic logic is_protected(input logic [14:0] a, input logic [1:0] bp);
        logic p;
        p = 1'b0;
        unique case (bp)
            BP_NONE:    p = 1'b0;
            BP_QUARTER: p = (a >= BOUND_QUARTER);
            BP_HALF:    p = (a >= BOUND_HALF);
            BP_ALL:     p = 1'b1;
        endcase
        return p;
    endfunction

    assign byte_in = {shift_reg[6:0], serial_in_in};

    // serial side next state, evaluated at each rising clock edge
    always_comb
    begin
        byte_cnt_next = byte_cnt_reg;
        bpos_next     = bpos_reg;
        cmd_next      = cmd_reg;
        req_next      = req_reg;
        shift_next    = shift_reg;
        addr_next     = addr_reg;
        pg_idx_next   = pg_idx_reg;
        pg_mask_next  = pg_mask_reg;
        sr_data_next  = sr_data_reg;
        pb_we         = 1'b0;
        // pause only moves with clock low, so it is stable here
        if (pause_n_in)
        begin
            shift_next = {shift_reg[14:0], serial_in_in};
            bpos_next  = bpos_reg + 3'h1;
            if (bpos_reg == BIT_LAST && byte_cnt_reg != BYTE_SAT)
                byte_cnt_next = byte_cnt_reg + 3'h1;
            // write armed only right after a data byte
            req_next.wr_armed = (cmd_reg == CMD_WRITE) && (bpos_reg == BIT_LAST)
                                && (byte_cnt_reg >= BYTE_DATA_FIRST);
            // status write armed between rises 16 and 17
            req_next.sr_armed = (cmd_reg == CMD_SR_WRITE) && (bpos_reg == BIT_LAST)
                                && (byte_cnt_reg == BYTE_SR_DATA);
            if (bpos_reg == BIT_LAST)
            begin
                if (byte_cnt_reg == BYTE_OPCODE)
                begin
                    cmd_next = decode_op(byte_in, busy_out);
                    req_next.wel_set = (decode_op(byte_in, busy_out) == CMD_WEL_SET);
                    req_next.wel_clr = (decode_op(byte_in, busy_out) == CMD_WEL_CLR);
                end
                else if (byte_cnt_reg == BYTE_SR_DATA && cmd_reg == CMD_SR_WRITE)
                    sr_data_next = byte_in;
                // only address-bearing commands may load the kept address, so that a
                // long status read during programming cannot move the page target
                else if (byte_cnt_reg == BYTE_ADDR_DONE && (cmd_reg == CMD_READ || cmd_reg == CMD_WRITE))
                begin
                    addr_next    = {shift_reg[14:0], serial_in_in};
                    pg_idx_next  = shift_reg[4:0] == 5'h0 && !serial_in_in ? 6'h0
                                 : {shift_reg[4:0], serial_in_in};
                    pg_mask_next = 64'h0;
                end
                else if (byte_cnt_reg >= BYTE_DATA_FIRST)
                begin
                    if (cmd_reg == CMD_READ)
                        addr_next = addr_reg + 16'h1;
                    // page byte stored, low bits wrap
                    if (cmd_reg == CMD_WRITE)
                    begin
                        pb_we                    = 1'b1;
                        pg_mask_next[pg_idx_reg] = 1'b1;
                        pg_idx_next              = pg_idx_reg + 6'h1;
                    end
                end
            end
        end
    end

    // serial side registers; select high clears the frame
    // select high resets, even while paused
    // reads end at any select rise
    // select rise clears any armed write
    always_ff @(posedge sck_in or posedge chip_select_n_in)
    begin
        if (chip_select_n_in)
        begin
            byte_cnt_reg <= 3'h0;
            bpos_reg     <= 3'h0;
            cmd_reg      <= CMD_NONE;
            req_reg      <= '0;
        end
        else
        begin
            byte_cnt_reg <= byte_cnt_next;
            bpos_reg     <= bpos_next;
            cmd_reg      <= cmd_next;
            req_reg      <= req_next;
        end
    end

    // data kept after the frame so the core can program from it
    always_ff @(posedge sck_in)
    begin
        shift_reg   <= shift_next;
        addr_reg    <= addr_next;
        pg_idx_reg  <= pg_idx_next;
        pg_mask_reg <= pg_mask_next;
        sr_data_reg <= sr_data_next;
        if (pb_we)
            page_buf[pg_idx_reg] <= byte_in;
    end

    // array read; contents are still here because programming refuses reads
    assign rd_byte = mem[addr_reg[MEM_AW-1:0]];

    // output bit chosen for the coming falling edge
    always_comb
    begin
        so_bit_next = so_bit_reg;
        so_en_next  = so_en_reg;
        // hold output bit while paused, resume at the same bit
        if (pause_n_in)
        begin
            so_en_next = 1'b0;
            // data from fall 24, msb first
            if (cmd_reg == CMD_READ && byte_cnt_reg >= BYTE_DATA_FIRST)
            begin
                so_en_next  = 1'b1;
                so_bit_next = rd_byte[~bpos_reg];
            end
            else if (cmd_reg == CMD_SR_READ && byte_cnt_reg >= BYTE_SR_DATA)
            begin
                so_en_next  = 1'b1;
                so_bit_next = status[~bpos_reg];
            end
        end
    end

    always_ff @(negedge sck_in or posedge chip_select_n_in)
    begin
        if (chip_select_n_in)
        begin
            so_bit_reg <= 1'b0;
            so_en_reg  <= 1'b0;
        end
        else
        begin
            so_bit_reg <= so_bit_next;
            so_en_reg  <= so_en_next;
        end
    end

    // released while paused or deselected; enable low drives
    assign serial_oe_n_out = ~(so_en_reg & ~chip_select_n_in & pause_n_in);
    assign serial_data_out = so_bit_reg;

    // two-stage synchronisers into the core clock, plus two delay stages
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            sync1_reg <= 6'h3F;
            sync2_reg <= 6'h3F;
            sync3_reg <= 6'h3F;
            sync4_reg <= 6'h3F;
        end
        else
        begin
            sync1_reg <= {chip_select_n_in, protect_n_in, req_reg};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            sync4_reg <= sync3_reg;
        end
    end

    assign cs_s     = sync2_reg[5];
    assign cs_d     = sync3_reg[5];
    assign prot_n_s = sync2_reg[4];
    assign req_s    = sync2_reg[3:0];
    assign req_d    = sync3_reg[3:0];
    // armed levels drop with select; look two cycles back to outrun the skew
    // select rising at a clock rise may fall either side of this
    assign req_old  = sync4_reg[3:0];

    // core sequencer: latch, status write, programming and timer
    always_comb
    begin
        state_next    = state_reg;
        timer_next    = timer_reg;
        prog_idx_next = prog_idx_reg;
        wel_next      = wel_reg;
        protect_pin_enable_next     = protect_pin_enable_reg;
        bp_next       = bp_reg;
        mem_we        = 1'b0;
        mem_waddr     = {addr_reg[MEM_AW-1:PAGE_AW], prog_idx_reg};
        // protect seen low in this frame; the set wins over the clear
        prot_low_next = ((cs_d & ~cs_s) ? 1'b0 : prot_low_reg) | (~cs_s & ~prot_n_s);
        unique case (state_reg)
            ST_IDLE:
            begin
                // latch set or clear once rise eight is seen
                if (req_s.wel_set && !req_d.wel_set)
                    wel_next = 1'b1;
                if (req_s.wel_clr && !req_d.wel_clr)
                    wel_next = 1'b0;
                if (cs_s && !cs_d)
                begin
                    if (req_old.wr_armed && wel_reg
                        && !is_protected(addr_reg[MEM_AW-1:0], bp_reg))
                    begin
                        state_next    = ST_PROG;
                        prog_idx_next = 6'h0;
                        timer_next    = TIMER_W'(PROG_CYCLES_P - 1);
                        wel_next      = 1'b0;
                    end
                    // protect pin counts only with enable set
                    else if (req_old.sr_armed && wel_reg && !(protect_pin_enable_reg && prot_low_reg))
                    begin
                        protect_pin_enable_next  = sr_data_reg[7];
                        bp_next    = sr_data_reg[3:2];
                        state_next = ST_WAIT;
                        timer_next = TIMER_W'(PROG_CYCLES_P - 1);
                        wel_next   = 1'b0;
                    end
                end
            end
            ST_PROG:
            begin
                // only bytes received in this page are programmed
                mem_we        = pg_mask_reg[prog_idx_reg];
                prog_idx_next = prog_idx_reg + 6'h1;
                timer_next    = timer_reg - TIMER_W'(1);
                if (prog_idx_reg == 6'h3F)
                    state_next = ST_WAIT;
            end
            ST_WAIT:
            begin
                timer_next = timer_reg - TIMER_W'(1);
                if (timer_reg == '0)
                    state_next = ST_IDLE;
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    // core registers
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_reg    <= ST_IDLE;
            timer_reg    <= '0;
            prog_idx_reg <= 6'h0;
            wel_reg      <= WEL_RST;
            protect_pin_enable_reg     <= PROTECT_PIN_ENABLE_RST;
            bp_reg       <= BP_RST;
            prot_low_reg <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            timer_reg    <= timer_next;
            prog_idx_reg <= prog_idx_next;
            wel_reg      <= wel_next;
            protect_pin_enable_reg     <= protect_pin_enable_next;
            bp_reg       <= bp_next;
            prot_low_reg <= prot_low_next;
        end
    end

    // array write port, one byte per core cycle
    always_ff @(posedge ref_clk_in)
    begin
        if (mem_we)
            mem[mem_waddr] <= page_buf[prog_idx_reg];
    end

    assign status.protect_pin_enable  = protect_pin_enable_reg;
    assign status.zero  = 3'h0;
    assign status.bp_hi = bp_reg[1];
    assign status.bp_lo = bp_reg[0];
    assign status.wel   = wel_reg;
    assign status.busy  = (state_reg != ST_IDLE);

    assign status_out = status;
    assign busy_out   = status.busy;

endmodule

// ==== eec_engine_asserts.sv ====
/*
 * eec_engine_asserts: port-level checks of the command engine.
 * Assumes it is bound to eec_spi_eeprom_engine and sees the core clock only.
 */
`timescale 1ns/10ps
module eec_engine_asserts
#(
    parameter int unsigned PROG_CYCLES_P = 200
)
(
    // clock and reset
    input wire logic       ref_clk_in,
    input wire logic       rst_n_in,
    // link inputs
    input wire logic       chip_select_n_in,
    input wire logic       pause_n_in,
    // watched outputs
    input wire logic       serial_oe_n_out,
    input wire logic [7:0] status_out,
    input wire logic       busy_out
);
    int unsigned busy_cnt_reg;
    int unsigned busy_cnt_next;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    // length of the present busy stretch, for the program time check
    always_comb
    begin
        busy_cnt_next = busy_out ? busy_cnt_reg + 1 : 0;
    end

    always_ff @(posedge ref_clk_in)
    begin
        busy_cnt_reg <= rst_n_in ? busy_cnt_next : 0;
    end

    a_oe_deselect: assert property (chip_select_n_in |-> serial_oe_n_out)
        else $error("output driven while deselected");
    a_oe_paused: assert property (!pause_n_in |-> serial_oe_n_out)
        else $error("output driven while paused");
    a_status_zeros: assert property (status_out[6:4] == 3'h0)
        else $error("status bits 6 to 4 not zero");
    a_busy_bit_live: assert property (status_out[0] == busy_out)
        else $error("status busy bit differs from busy");
    a_reset_status: assert property (disable iff (1'b0) !rst_n_in ##1 !rst_n_in |-> status_out == 8'h00)
        else $error("status not cleared by reset");
    a_busy_after_cs: assert property ($rose(busy_out) |-> $past(chip_select_n_in, 2))
        else $error("program cycle began with select low");
    a_busy_length: assert property ($fell(busy_out) |->
        busy_cnt_reg >= PROG_CYCLES_P - 1 && busy_cnt_reg <= PROG_CYCLES_P + 2)
        else $error("program cycle length wrong");
    a_latch_autoclr: assert property ($rose(busy_out) |-> ##[0:2] !status_out[1])
        else $error("latch not cleared by program cycle");
    a_latch_busy: assert property (busy_out && $past(busy_out) |-> !$rose(status_out[1]))
        else $error("latch set accepted while busy");

    // main scenarios reached
    c_program: cover property ($rose(busy_out));
    c_latch: cover property ($rose(status_out[1]));
    c_drive: cover property (!serial_oe_n_out);
    c_pause: cover property (!pause_n_in && !chip_select_n_in);
endmodule

bind eec_spi_eeprom_engine eec_engine_asserts #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_chk (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .chip_select_n_in(chip_select_n_in),
    .pause_n_in(pause_n_in), .serial_oe_n_out(serial_oe_n_out), .status_out(status_out),
    .busy_out(busy_out));

// ==== eec_host_model.sv ====
/*
 * eec_host_model: behavioural bus controller facing the engine's link.
 * Assumes a 12 ns serial clock that stands low between frames.
 */
`timescale 1ns/10ps
module eec_host_model (
    // link towards the device
    output logic      sck_out,
    output logic      chip_select_n_out,
    output logic      si_out,
    output logic      pause_n_out,
    // device answer
    input  wire logic so_in,
    input  wire logic so_oe_n_in
);
    int   pause_at = -1;
    logic oe_in_pause;
    logic so_last;
    logic so_wire;

    // a released line shows the inverse of its last bit, never a stale copy
    assign so_wire = so_oe_n_in ? ~so_last : so_in;

    initial
    begin
        sck_out = 1'b0;
        chip_select_n_out = 1'b0;
        si_out = 1'b0;
        pause_n_out = 1'b1;
        so_last = 1'b0;
        // a clean select rise once every process runs clears the frame state
        #1 chip_select_n_out = 1'b1;
    end

    // one frame of nb bits, msb of tx first, read bits shifted into rx
    task automatic xfer(input int nb, input logic [63:0] tx, output logic [63:0] rx);
        rx = '0;
        chip_select_n_out = 1'b0;
        // odd offset keeps link edges off the core clock edges
        #21;
        for (int i = 0; i < nb; i++)
        begin
            // input set up while the clock is low
            si_out = tx[63 - i];
            if (i == pause_at)
            begin
                // pause lowered with the clock low, select kept low
                // kept clear of the falling edge, which samples pause and holds the output bit
                #2 pause_n_out = 1'b0;
                si_out = ~si_out;
                repeat (2)
                begin
                    #6 sck_out = 1'b1;
                    #6 sck_out = 1'b0;
                end
                #2 oe_in_pause = so_oe_n_in;
                // released with the clock low, held bit offered again
                si_out = tx[63 - i];
                pause_n_out = 1'b1;
            end
            #6 sck_out = 1'b1;
            rx = {rx[62:0], so_wire};
            so_last = so_oe_n_in ? so_last : so_in;
            #6 sck_out = 1'b0;
        end
        // select rises with the clock low, before any further rise
        #30 chip_select_n_out = 1'b1;
        #39;
    endtask
endmodule

// ==== spi_eeprom_command_engine_tb_top.sv ====
/*
 * spi_eeprom_command_engine_tb_top: directed bench of the command engine.
 * Assumes the host model makes the serial clock; program time cut to 200.
 */
`timescale 1ns/10ps
module spi_eeprom_command_engine_tb_top
    import eec_pkg::*;
;
    logic        ref_clk;
    logic        rst_n = 1'b0;
    logic        protect_n = 1'b1;
    logic        sck;
    logic        cs_n;
    logic        si;
    logic        pause_n;
    logic        so;
    logic        oe_n;
    logic [7:0]  status;
    logic        busy;
    logic [63:0] rx;
    int          fails = 0;
    int          checks_done = 0;

    eec_spi_eeprom_engine #(.PROG_CYCLES_P(200)) u_dut (
        .ref_clk_in(ref_clk), .rst_n_in(rst_n), .sck_in(sck), .chip_select_n_in(cs_n),
        .serial_in_in(si), .pause_n_in(pause_n), .protect_n_in(protect_n),
        .serial_data_out(so), .serial_oe_n_out(oe_n), .status_out(status), .busy_out(busy));
    eec_host_model u_host (
        .sck_out(sck), .chip_select_n_out(cs_n), .si_out(si), .pause_n_out(pause_n),
        .so_in(so), .so_oe_n_in(oe_n));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // small frame helpers shared by all scenarios
    task automatic cmd(input logic [7:0] op);
        u_host.xfer(8, {op, 56'h0}, rx);
    endtask
    task automatic sr_rd(input logic [7:0] exp, input logic [7:0] mask);
        u_host.xfer(16, {OP_SR_READ, 56'h0}, rx);
        check(rx[7:0] & mask, exp);
    endtask
    task automatic wr(input int nb, input logic [15:0] a, input logic [31:0] d);
        u_host.xfer(nb, {OP_WRITE, a, d, 8'h0}, rx);
    endtask
    task automatic rd2(input logic [15:0] a, input logic [15:0] exp);
        u_host.xfer(40, {OP_READ, a, 40'h0}, rx);
        check(rx[15:8], exp[15:8]);
        check(rx[7:0], exp[7:0]);
    endtask
    task automatic busy_is(input logic e);
        check({7'h0, busy}, {7'h0, e});
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        // busy looked at away from the edge that moves it
        while (busy !== 1'b0 && n < 1000)
        begin
            @(negedge ref_clk);
            n++;
        end
        busy_is(1'b0);
    endtask

    // latch set, clear, and set cut short at seven bits
    task automatic t_latch();
        cmd(OP_WEL_SET);
        sr_rd(8'h02, 8'hFF);
        cmd(OP_WEL_CLR);
        sr_rd(8'h00, 8'hFF);
        u_host.xfer(7, {OP_WEL_SET, 56'h0}, rx);
        sr_rd(8'h00, 8'hFF);
    endtask

    // page write across the page end, then read wrap over the top
    task automatic t_page();
        cmd(OP_WEL_SET);
        wr(56, 16'h003E, 32'h11223344);
        wait_idle();
        sr_rd(8'h00, 8'hFF);
        rd2(16'h003E, 16'h1122);
        rd2(16'h0000, 16'h3344);
        cmd(OP_WEL_SET);
        wr(32, 16'h7FFF, 32'hAB000000);
        wait_idle();
        rd2(16'h7FFF, 16'hAB33);
    endtask

    // writes refused, cancelled, and commands refused while busy
    task automatic t_refuse();
        wr(32, 16'h0000, 32'h77000000);
        busy_is(1'b0);
        cmd(OP_WEL_SET);
        wr(31, 16'h0000, 32'h77000000);
        busy_is(1'b0);
        cmd(OP_WEL_SET);
        wr(32, 16'h0001, 32'h55000000);
        busy_is(1'b1);
        cmd(OP_WEL_SET);
        sr_rd(8'h01, 8'hFF);
        wait_idle();
        rd2(16'h0000, 16'h3355);
    endtask

    // pause in mid data with clocks toggling, then resume
    task automatic t_pause();
        u_host.pause_at = 30;
        rd2(16'h003E, 16'h1122);
        check({7'h0, u_host.oe_in_pause}, 8'h01);
        u_host.pause_at = -1;
    endtask

    // status writes: field mask, protect pin, select timing, block protect
    task automatic t_status();
        cmd(OP_WEL_SET);
        u_host.xfer(16, {OP_SR_WRITE, 8'hFF, 48'h0}, rx);
        wait_idle();
        sr_rd(8'h8C, 8'hFF);
        cmd(OP_WEL_SET);
        wr(32, 16'h0100, 32'h66000000);
        busy_is(1'b0);
        @(posedge ref_clk) protect_n <= 1'b0;
        cmd(OP_WEL_SET);
        u_host.xfer(16, {OP_SR_WRITE, 8'h04, 48'h0}, rx);
        sr_rd(8'h8C, 8'hFD);
        @(posedge ref_clk) protect_n <= 1'b1;
        cmd(OP_WEL_SET);
        u_host.xfer(15, {OP_SR_WRITE, 8'h04, 48'h0}, rx);
        sr_rd(8'h8C, 8'hFD);
        u_host.xfer(17, {OP_SR_WRITE, 8'h04, 48'h0}, rx);
        sr_rd(8'h8C, 8'hFD);
        cmd(OP_WEL_SET);
        u_host.xfer(16, {OP_SR_WRITE, 8'h04, 48'h0}, rx);
        wait_idle();
        sr_rd(8'h04, 8'hFF);
        cmd(OP_WEL_SET);
        wr(32, 16'h6000, 32'h77000000);
        busy_is(1'b0);
        wr(32, 16'h5FFF, 32'h77000000);
        busy_is(1'b1);
        wait_idle();
    endtask

    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(status, 8'h00);
        t_latch();
        t_page();
        t_refuse();
        t_pause();
        t_status();
        end_sim();
    end

    // hang guard, far beyond the twenty or so microseconds needed
    initial
    begin
        #200000;
        fails++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        end_sim();
    end
endmodule
